// file: rtl/mms_pkg.sv
// Purpose: shared constants and types for the measurement mode sequencer
// Assumes: 32-bit APB, 100 MHz pclk
// Notes: conversion and heat times are stand-in counts for simulation
package mms_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL_MEAS = 8'h00; // mode and oversampling
  localparam logic [7:0] OFF_CTRL_GAS = 8'h04; // gas enable and profile select
  localparam logic [7:0] OFF_STATUS = 8'h08; // read-only state
  localparam logic [7:0] OFF_HEAT_BASE = 8'h40; // ten profile words, 4 apart
  localparam logic [7:0] OFF_HEAT_LAST = 8'h64; // last profile word
  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int MODE_LSB = 0; // mode<1:0>
  localparam int OSR_P_LSB = 2; // pressure oversampling<2:0>
  localparam int OSR_T_LSB = 5; // temperature oversampling<2:0>
  localparam int OSR_H_LSB = 8; // humidity oversampling<2:0>
  localparam int SEL_LSB = 0; // heater_profile_select<3:0>
  localparam int RUN_GAS_BIT = 4; // gas-run enable
  localparam int HEAT_TEMP_LSB = 0; // target temperature code<7:0>
  localparam int HEAT_DUR_LSB = 8; // heating duration<7:0>
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_FORCED = 2'h1;
  localparam logic [2:0] OSR_SKIP = 3'h0;
  localparam int NUM_PROFILES = 10;
  localparam logic [3:0] LAST_PROFILE = 4'h9;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 10;
  localparam int CONV_NS = 160; // one conversion step per oversample
  localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int HEAT_UNIT_NS = 40; // one heating-duration count
  localparam int HEAT_UNIT_CYC = (HEAT_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] CONV_CYC16 = 16'(CONV_CYC);
  localparam logic [15:0] HEAT_UNIT16 = 16'(HEAT_UNIT_CYC);
  // ----------------------------------------
  // sequencer states, gray from sleep through gas; gas back to sleep flips all three bits
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_SLEEP = 3'h0,
    ST_TEMP = 3'h1,
    ST_PRES = 3'h3,
    ST_HUM = 3'h2,
    ST_HEAT = 3'h6,
    ST_GAS = 3'h7
  } seq_state_t;
endpackage

// file: rtl/heater_profile_mem.sv
// Purpose: ten-slot heater profile store
// Assumes: one write port, one registered read port
// Notes: read data follow the address by one cycle
`timescale 1ns/1ps
module heater_profile_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [3:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [15:0] mem_q [mms_pkg::NUM_PROFILES]; // slots zero to nine
  logic [15:0] rd_q; // registered read word
  logic [15:0] rd_d;

  // ----------------------------------------
  // read select
  // ----------------------------------------
  always_comb begin
    rd_d = 16'h0000;
    if (rd_addr <= mms_pkg::LAST_PROFILE) begin
      rd_d = mem_q[rd_addr];
    end
  end

  // store and register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < mms_pkg::NUM_PROFILES; i++) begin
        mem_q[i] <= 16'h0000;
      end
      rd_q <= 16'h0000;
    end else begin
      if (wr_en && wr_addr <= mms_pkg::LAST_PROFILE) begin
        mem_q[wr_addr] <= wr_data;
      end
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;
endmodule

// file: rtl/measurement_mode_sequencer.sv
// Purpose: sleep/forced mode control and one measurement cycle sequencer
// Assumes: APB slave, zero wait states, single clock
// Notes: conversions are modelled as timed phases; analog work is outside
`timescale 1ns/1ps
// How it works
// - reset leaves the device asleep, idle
// - sleep code means no measurements run
// - forced code starts one full cycle
// - cycle end returns mode to sleep
// - phases run temperature, pressure, humidity, gas
// - heater on only in gas heating and gas conversion
// - ten heater slots with temperature, duration
// - sleep/forced codes written during measurement are deferred; oversampling applies at once
// - while deferred, control writes are dropped
// - cycle uses the selected heater slot
// - gas runs only when enable set
// - zero oversampling skips that sub-measurement
module measurement_mode_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic heater_on,
  output logic [7:0] heater_target,
  output logic adc_busy,
  output logic [1:0] adc_channel
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  mms_pkg::seq_state_t st_q, st_d; // sequencer state
  logic [1:0] mode_q, mode_d; // operating mode field
  logic [8:0] osr_q, osr_d; // h,t,p oversampling fields
  logic [3:0] sel_q, sel_d; // heater_profile_select
  logic run_gas_q, run_gas_d; // gas-run enable
  logic pend_q, pend_d; // a deferred mode change waits
  logic [1:0] pend_mode_q, pend_mode_d; // the deferred code
  logic [15:0] cnt_q, cnt_d; // phase timer
  logic [31:0] rdata_q, rdata_d; // read data register
  logic [15:0] prof_word; // selected slot, registered
  logic wr, rd; // access phase strobes
  logic heat_wr; // profile slot write
  logic [3:0] heat_idx; // slot index from address
  logic busy; // a measurement is running
  logic heat_q, heat_d; // heater drive
  logic [7:0] target_q, target_d; // heater set-point shown
  logic conv_q, conv_d; // a conversion runs
  logic [1:0] chan_q, chan_d; // channel in use

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign heat_idx = 4'((paddr - mms_pkg::OFF_HEAT_BASE) >> 2);
  assign busy = (st_q != mms_pkg::ST_SLEEP);

  // decoded address is mapped
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == mms_pkg::OFF_CTRL_MEAS) || (a == mms_pkg::OFF_CTRL_GAS) ||
             (a == mms_pkg::OFF_STATUS) ||
             (a >= mms_pkg::OFF_HEAT_BASE && a <= mms_pkg::OFF_HEAT_LAST &&
              a[1:0] == 2'h0);
  endfunction

  // cycles for a conversion of given oversampling code
  function automatic logic [15:0] conv_len(input logic [2:0] osr);
    conv_len = 16'(mms_pkg::CONV_CYC16 * (16'h0001 << (osr - 3'h1)));
  endfunction

  assign pslverr = psel && penable && !mapped(paddr);
  assign heat_wr = wr && !pend_q && mapped(paddr) &&
                   paddr >= mms_pkg::OFF_HEAT_BASE;

  // ----------------------------------------
  // heater profile store
  // ----------------------------------------
  heater_profile_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(heat_wr),
    .wr_addr(heat_idx),
    .wr_data(pwdata[15:0]),
    .rd_addr(sel_q),
    .rd_data(prof_word)
  );

  // first phase at or after a given one whose work is enabled
  function automatic mms_pkg::seq_state_t next_phase(input logic [2:0] from,
                                                     input logic [8:0] o,
                                                     input logic g);
    next_phase = mms_pkg::ST_SLEEP;
    if (g) next_phase = mms_pkg::ST_HEAT;
    if (from <= 3'h2 && o[8:6] != mms_pkg::OSR_SKIP) next_phase = mms_pkg::ST_HUM;
    if (from <= 3'h1 && o[2:0] != mms_pkg::OSR_SKIP) next_phase = mms_pkg::ST_PRES;
    if (from == 3'h0 && o[5:3] != mms_pkg::OSR_SKIP) next_phase = mms_pkg::ST_TEMP;
  endfunction

  // ----------------------------------------
  // control, sequencing and registers
  // ----------------------------------------
  always_comb begin
    logic [1:0] wmode;
    logic go;
    wmode = pwdata[mms_pkg::MODE_LSB +: 2];
    go = 1'b0;
    st_d = st_q;
    mode_d = mode_q;
    osr_d = osr_q;
    sel_d = sel_q;
    run_gas_d = run_gas_q;
    pend_d = pend_q;
    pend_mode_d = pend_mode_q;
    cnt_d = cnt_q;
    rdata_d = rdata_q;
    // register writes
    if (wr && !pend_q) begin
      if (paddr == mms_pkg::OFF_CTRL_MEAS) begin
        if (busy) begin
          if (wmode == mms_pkg::MODE_SLEEP || wmode == mms_pkg::MODE_FORCED) begin
            pend_d = 1'b1;
            pend_mode_d = wmode;
          end
          osr_d = {pwdata[mms_pkg::OSR_H_LSB +: 3], pwdata[mms_pkg::OSR_T_LSB +: 3],
                   pwdata[mms_pkg::OSR_P_LSB +: 3]};
        end else begin
          osr_d = {pwdata[mms_pkg::OSR_H_LSB +: 3], pwdata[mms_pkg::OSR_T_LSB +: 3],
                   pwdata[mms_pkg::OSR_P_LSB +: 3]};
          if (wmode == mms_pkg::MODE_FORCED) begin
            mode_d = mms_pkg::MODE_FORCED;
            go = 1'b1;
          end else if (wmode == mms_pkg::MODE_SLEEP) begin
            mode_d = mms_pkg::MODE_SLEEP;
          end
          // other codes leave mode and state alone
        end
      end else if (paddr == mms_pkg::OFF_CTRL_GAS) begin
        sel_d = pwdata[mms_pkg::SEL_LSB +: 4];
        run_gas_d = pwdata[mms_pkg::RUN_GAS_BIT];
      end
    end
    // sequencer
    unique case (st_q)
      mms_pkg::ST_SLEEP: begin
        if (go) begin
          st_d = next_phase(3'h0, osr_d, run_gas_d);
          cnt_d = 16'h0000;
          if (st_d == mms_pkg::ST_SLEEP) mode_d = mms_pkg::MODE_SLEEP;
        end
      end
      mms_pkg::ST_TEMP, mms_pkg::ST_PRES, mms_pkg::ST_HUM, mms_pkg::ST_HEAT,
      mms_pkg::ST_GAS: begin
        cnt_d = cnt_q + 16'h0001;
        if ((st_q == mms_pkg::ST_TEMP && cnt_d >= conv_len(osr_q[5:3])) ||
            (st_q == mms_pkg::ST_PRES && cnt_d >= conv_len(osr_q[2:0])) ||
            (st_q == mms_pkg::ST_HUM && cnt_d >= conv_len(osr_q[8:6])) ||
            (st_q == mms_pkg::ST_HEAT &&
             cnt_d >= 16'(prof_word[mms_pkg::HEAT_DUR_LSB +: 8] * mms_pkg::HEAT_UNIT16)) ||
            (st_q == mms_pkg::ST_GAS && cnt_d >= mms_pkg::CONV_CYC16)) begin
          cnt_d = 16'h0000;
          unique case (st_q)
            mms_pkg::ST_TEMP: st_d = next_phase(3'h1, osr_q, run_gas_q);
            mms_pkg::ST_PRES: st_d = next_phase(3'h2, osr_q, run_gas_q);
            mms_pkg::ST_HUM: st_d = next_phase(3'h3, osr_q, run_gas_q);
            mms_pkg::ST_HEAT: st_d = mms_pkg::ST_GAS;
            default: st_d = mms_pkg::ST_SLEEP;
          endcase
          if (st_d == mms_pkg::ST_SLEEP) begin
            mode_d = mms_pkg::MODE_SLEEP;
            // a mode write in this last cycle counts too, or pend would stick in sleep
            if (pend_d) begin
              pend_d = 1'b0;
              if (pend_mode_d == mms_pkg::MODE_FORCED) begin
                mode_d = mms_pkg::MODE_FORCED;
                st_d = next_phase(3'h0, osr_d, run_gas_d);
                if (st_d == mms_pkg::ST_SLEEP) mode_d = mms_pkg::MODE_SLEEP;
              end
            end
          end
        end
      end
      default: st_d = mms_pkg::ST_SLEEP;
    endcase
    // read data
    rdata_d = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (paddr == mms_pkg::OFF_CTRL_MEAS) begin
        rdata_d[mms_pkg::MODE_LSB +: 2] = mode_q;
        rdata_d[mms_pkg::OSR_P_LSB +: 3] = osr_q[2:0];
        rdata_d[mms_pkg::OSR_T_LSB +: 3] = osr_q[5:3];
        rdata_d[mms_pkg::OSR_H_LSB +: 3] = osr_q[8:6];
      end else if (paddr == mms_pkg::OFF_CTRL_GAS) begin
        rdata_d[mms_pkg::SEL_LSB +: 4] = sel_q;
        rdata_d[mms_pkg::RUN_GAS_BIT] = run_gas_q;
      end else if (paddr == mms_pkg::OFF_STATUS) begin
        rdata_d[2:0] = st_q;
        rdata_d[3] = busy;
        rdata_d[4] = pend_q;
      end
    end else if (rd) begin
      rdata_d = rdata_q;
    end
  end

  // registers; reset lands in sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= mms_pkg::ST_SLEEP;
      mode_q <= mms_pkg::MODE_SLEEP;
      osr_q <= 9'h000;
      sel_q <= 4'h0;
      run_gas_q <= 1'b0;
      pend_q <= 1'b0;
      pend_mode_q <= mms_pkg::MODE_SLEEP;
      cnt_q <= 16'h0000;
      rdata_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      osr_q <= osr_d;
      sel_q <= sel_d;
      run_gas_q <= run_gas_d;
      pend_q <= pend_d;
      pend_mode_q <= pend_mode_d;
      cnt_q <= cnt_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = rdata_q;

  // decode the next state so the registered drives line up with st_q
  always_comb begin
    heat_d = (st_d == mms_pkg::ST_HEAT) || (st_d == mms_pkg::ST_GAS);
    target_d = 8'h00; // no set-point while the plate is cold
    if (heat_d) begin
      target_d = prof_word[mms_pkg::HEAT_TEMP_LSB +: 8];
    end
    conv_d = (st_d != mms_pkg::ST_SLEEP) && (st_d != mms_pkg::ST_HEAT);
    chan_d = 2'h0; // temperature, or no conversion running
    if (st_d == mms_pkg::ST_PRES) begin
      chan_d = 2'h1;
    end else if (st_d == mms_pkg::ST_HUM) begin
      chan_d = 2'h2;
    end else if (st_d == mms_pkg::ST_GAS) begin
      chan_d = 2'h3;
    end
  end

  // output drive registers, all off in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      heat_q <= 1'b0;
      target_q <= 8'h00;
      conv_q <= 1'b0;
      chan_q <= 2'h0;
    end else begin
      heat_q <= heat_d;
      target_q <= target_d;
      conv_q <= conv_d;
      chan_q <= chan_d;
    end
  end

  assign heater_on = heat_q;
  assign heater_target = target_q;
  assign adc_busy = conv_q;
  assign adc_channel = chan_q;
endmodule

// file: testbench/mms_monitor.sv
// Purpose: port-level checks of the measurement mode sequencer
// Assumes: one pclk domain, presetn asynchronous and active low
// Notes: idle means neither converting nor heating
`timescale 1ns/1ps
module mms_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic heater_on,
  input wire logic [7:0] heater_target,
  input wire logic adc_busy,
  input wire logic [1:0] adc_channel
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // decoded helpers
  // ----------------------------------------
  wire acc = psel && penable; // access phase
  wire idle = !adc_busy && !heater_on; // sequencer asleep
  wire gas = adc_busy && adc_channel == 2'h3; // gas conversion
  wire mode_wr = acc && pwrite && paddr == mms_pkg::OFF_CTRL_MEAS;
  wire forced = pwdata[1:0] == mms_pkg::MODE_FORCED;
  wire mapped = paddr[1:0] == 2'h0 && (paddr <= mms_pkg::OFF_STATUS ||
    (paddr >= mms_pkg::OFF_HEAT_BASE && paddr <= mms_pkg::OFF_HEAT_LAST));
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_RST_IDLE: assert property (!$past(presetn) |-> idle)
    else $error("not idle after reset");
  AST_FORCED_START: assert property (mode_wr && forced && idle &&
    pwdata[7:5] != mms_pkg::OSR_SKIP |=> adc_busy && adc_channel == 2'h0)
    else $error("forced write did not start temperature");
  AST_SLEEP_STAY: assert property (mode_wr && !forced && idle |=> idle)
    else $error("non-forced mode code started activity");
  AST_HEAT_GAS_ONLY: assert property (heater_on |-> !adc_busy || gas)
    else $error("heater on outside gas phase");
  AST_TARGET_OFF: assert property (!heater_on |-> heater_target == 8'h00)
    else $error("heater target shown while heater off");
  AST_GAS_HEATED: assert property (gas |-> heater_on)
    else $error("gas conversion without heater");
  AST_HEAT_THEN_GAS: assert property (heater_on && !adc_busy ##1 adc_busy |-> gas)
    else $error("heating not followed by gas conversion");
  // a gas conversion lasts exactly sixteen cycles
  AST_GAS_LEN: assert property ($rose(gas) |-> gas [*8] ##1 gas [*8] ##1 !gas)
    else $error("gas conversion length wrong");
  AST_SLVERR: assert property (acc |-> pready && pslverr == !mapped)
    else $error("bus answer wrong");
  // main scenarios
  cover property ($rose(gas));
  cover property (mode_wr && !idle);
  cover property (acc && pslverr);
endmodule

// file: testbench/mms_host.sv
// Purpose: host controller model driving the register bus
// Assumes: APB; slave raises pready when done
// Notes: all signals move just after a rising edge
`timescale 1ns/1ps
module mms_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // bus parked at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one transfer: setup, access until pready, then release
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // released data is not left showing
  endtask
endmodule

// file: testbench/measurement_mode_sequencer_tb_top.sv
// Purpose: self-checking bench of the measurement mode sequencer
// Assumes: 100 MHz pclk, reset low for 5 cycles
// Notes: phases traced as nibbles: 0..3 channel, 4 heating, 7 idle
`timescale 1ns/1ps
module measurement_mode_sequencer_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, heater_on, adc_busy, er;
  logic [7:0] paddr, heater_target;
  logic [31:0] pwdata, prdata, rd, trace;
  logic [1:0] adc_channel;
  logic [2:0] ph, last = 3'h7;
  logic [7:0] tgt; // target seen while heating
  int gas_cnt = 0;
  int err_total = 0;
  int comparisons = 0;
  typedef struct packed {logic [7:0] a; logic [31:0] wd; logic [31:0] ex; logic ee;} row_t;
  row_t rows [9] = '{
    {8'h00, 32'h7FC, 32'h7FC, 1'b0}, {8'h00, 32'h6, 32'h4, 1'b0},
    {8'h00, 32'h3, 32'h0, 1'b0}, {8'h04, 32'h1F, 32'h1F, 1'b0},
    {8'h08, 32'hFF, 32'h0, 1'b0}, {8'h40, 32'hFFFF, 32'h0, 1'b0},
    {8'h64, 32'hFFFF, 32'h0, 1'b0}, {8'h68, 32'h1, 32'h0, 1'b1},
    {8'h0C, 32'h1, 32'h0, 1'b1}};
  always #5 pclk = ~pclk;
  measurement_mode_sequencer measurement_mode_sequencer_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .heater_on(heater_on),
    .heater_target(heater_target), .adc_busy(adc_busy), .adc_channel(adc_channel));
  mms_host mms_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // phase trace, gas count and heater target seen
  always @(posedge pclk) begin
    ph = (heater_on && !adc_busy) ? 3'h4 : adc_busy ? {1'b0, adc_channel} : 3'h7;
    if (ph !== last) begin
      trace = {trace[27:0], 1'b0, ph};
      if (ph == 3'h3) gas_cnt++;
    end
    if (heater_on) tgt = heater_target;
    last = ph;
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    mms_host_inst.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    mms_host_inst.xfer(1'b0, a, 32'h0, rd, er);
    chk_word(rd, exp);
  endtask
  task automatic wait_idle();
    @(posedge pclk);
    while (adc_busy || heater_on) @(posedge pclk);
    @(posedge pclk); // let the phase trace take the last edge first
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    #50000;
    err_total++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // register table
    foreach (rows[i]) begin
      mms_host_inst.xfer(1'b1, rows[i].a, rows[i].wd, rd, er);
      chk_word({31'h0, er}, {31'h0, rows[i].ee});
      mms_host_inst.xfer(1'b0, rows[i].a, 32'h0, rd, er);
      chk_word({rd[31:1], er}, {rows[i].ex[31:1], rows[i].ee});
    end
    $display("test table done");
    // deferred forced write, dropped writes while pending
    wr(8'h4C, 32'h2A5);
    wr(8'h04, 32'h13);
    wr(8'h00, 32'h121);
    wr(8'h00, 32'h121);
    mms_host_inst.xfer(1'b0, 8'h08, 32'h0, rd, er);
    chk_word({31'h0, rd[4]}, 32'h1);
    wr(8'h04, 32'h0);
    wr(8'h4C, 32'h0);
    while (gas_cnt < 2) @(posedge pclk);
    wait_idle();
    rd_chk(8'h04, 32'h13);
    chk_word(32'(gas_cnt), 32'h2);
    chk_word({24'h0, tgt}, 32'hA5);
    $display("test deferred done");
    // order of phases, gas disabled, skipped stages
    wr(8'h04, 32'h03);
    trace = 32'h0;
    wr(8'h00, 32'h125);
    wait_idle();
    chk_word(trace, 32'h127);
    rd_chk(8'h00, 32'h124);
    trace = 32'h0;
    wr(8'h00, 32'h101);
    wait_idle();
    chk_word(trace, 32'h27);
    chk_word(32'(gas_cnt), 32'h2);
    // forced with every stage skipped and no gas falls straight back to sleep
    wr(8'h00, 32'h1);
    rd_chk(8'h00, 32'h0);
    $display("test order done");
    // reset in mid-measurement
    wr(8'h00, 32'h121);
    repeat (4) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_word({31'h0, adc_busy}, 32'h0);
    presetn <= 1'b1;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h0);
    $display("test reset done");
    finish_test();
  end
endmodule
bind measurement_mode_sequencer mms_monitor mms_monitor_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .heater_on(heater_on), .heater_target(heater_target),
  .adc_busy(adc_busy), .adc_channel(adc_channel));
